// ===== flash_host.sv
// SPI master that frames flash commands ordered over AHB-Lite registers.
// Assumes one flash on cs_n/sclk/mosi/miso; miso is asynchronous to hclk.
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module flash_host
	import flash_host_pkg::*;
(
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	output flash_host_pkg::spi_out_t    spi_out,
	input  wire logic                   miso
);
	import flash_host_pkg::*;

	// ************************************************************
	// Bus slave
	// ************************************************************
	logic        ap_wr_q;
	logic [7:0]  ap_ofs_q;
	logic [31:0] hrdata_q;
	cmd_t        cmd_q, cmd_d;
	logic [23:0] addr_q;
	logic [7:0]  txd_q, rxd_q, div_q;
	logic        rx_valid_q, tx_need_q;
	logic        busy_q;

	wire addr_phase = hsel & hready & htrans[1];
	wire wr_ctrl    = ap_wr_q & (ap_ofs_q == CTRL_OFS);
	wire wr_txd     = ap_wr_q & (ap_ofs_q == TXD_OFS);
	// Cleared with the capture, so a byte landing meanwhile stays flagged
	wire rd_rxd     = addr_phase & ~hwrite & (haddr[7:0] == RXD_OFS);
	// Starting is refused while a frame runs; unknown opcodes never go out
	wire start      = wr_ctrl & hwdata[CTRL_GO_BIT] & ~busy_q
	                  & known_op(hwdata[7:0]);

	wire [31:0] rd_mux =
		(haddr[7:0] == STAT_OFS) ? {29'h0, tx_need_q, rx_valid_q, busy_q} :
		(haddr[7:0] == RXD_OFS)  ? {24'h0, rxd_q} :
		(haddr[7:0] == ADDR_OFS) ? {8'h0, addr_q} :
		(haddr[7:0] == DIV_OFS)  ? {24'h0, div_q} :
		(haddr[7:0] == CTRL_OFS) ? {cmd_q.go, cmd_q.rd, 2'h0, cmd_q.ndat, 2'h0, cmd_q.ndum,
		                          2'h0, cmd_q.naddr, cmd_q.op} : 32'h0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr_q  <= 1'b0;
			ap_ofs_q <= 8'h00;
		end
		else
		begin
			ap_wr_q  <= addr_phase & hwrite;
			ap_ofs_q <= haddr[7:0];
		end
	end

	// Zero wait state: read data registered in the address phase
	// A read right behind a write to the same register sees the old value
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= 32'h0;
		else if (addr_phase & ~hwrite)
			hrdata_q <= rd_mux;
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_comb
	begin
		cmd_d = cmd_q;
		if (start)
		begin
			cmd_d.op    = hwdata[7:0];
			cmd_d.naddr = hwdata[CTRL_NADDR_LSB +: 2];
			cmd_d.ndum  = hwdata[CTRL_NDUM_LSB +: 2];
			cmd_d.ndat  = hwdata[CTRL_NDAT_LSB +: 12];
			cmd_d.rd    = hwdata[CTRL_RD_BIT];
			cmd_d.go    = 1'b1;
		end
		else if (!busy_q)
			cmd_d.go = 1'b0;
	end

	// ************************************************************
	// Serial sequencer
	// ************************************************************
	seq_state_t  st_q;
	phase_t      ph_q;
	logic [7:0]  div_cnt_q;
	logic [2:0]  bit_q;
	logic [7:0]  sh_q;
	logic [11:0] cnt_q;
	logic        sclk_q, cs_n_q, mosi_q;
	logic        miso_m_q, miso_s_q;

	wire tick      = (div_cnt_q == 8'h00);
	wire last_bit  = (bit_q == 3'd7);
	wire in_read   = (ph_q == PH_DATA) & cmd_q.rd;
	wire in_write  = (ph_q == PH_DATA) & ~cmd_q.rd;
	// Data writes stall until software supplies the byte
	wire can_shift = ~(in_write & tx_need_q);

	// Address high byte first; count 3 starts at bits 23:16
	function automatic logic [7:0] addr_pick(input logic [23:0] a, input logic [1:0] idx);
		return (idx == 2'd3) ? a[23:16] : (idx == 2'd2) ? a[15:8] : a[7:0];
	endfunction

	wire [1:0] a_idx      = cnt_q[1:0] - 2'd1;
	wire [7:0] addr_first = addr_pick(addr_q, cmd_q.naddr);
	wire [7:0] addr_byte  = addr_pick(addr_q, a_idx);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			miso_m_q <= 1'b0;
			miso_s_q <= 1'b0;
		end
		else
		begin
			miso_m_q <= miso;
			miso_s_q <= miso_m_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			div_cnt_q <= DIV_RESET;
		else if (tick || st_q == S_IDLE)
			div_cnt_q <= div_q;
		else
			div_cnt_q <= div_cnt_q - 8'd1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q       <= S_IDLE;
			ph_q       <= PH_OP;
			bit_q      <= 3'd0;
			sh_q       <= 8'h00;
			cnt_q      <= 12'd0;
			sclk_q     <= 1'b0;
			cs_n_q     <= 1'b1;
			mosi_q     <= 1'b0;
			busy_q     <= 1'b0;
			rxd_q      <= 8'h00;
			rx_valid_q <= 1'b0;
			tx_need_q  <= 1'b0;
			cmd_q      <= '0;
			addr_q     <= 24'h0;
			txd_q      <= 8'h00;
			div_q      <= DIV_RESET;
		end
		else
		begin
			cmd_q <= cmd_d;
			if (ap_wr_q & (ap_ofs_q == ADDR_OFS) & ~busy_q)
				addr_q <= hwdata[23:0];
			// Two-flop miso sync needs three hclk cycles per sclk phase
			if (ap_wr_q & (ap_ofs_q == DIV_OFS) & ~busy_q)
				div_q <= (hwdata[7:0] < 8'h02) ? 8'h02 : hwdata[7:0];
			if (wr_txd)
			begin
				txd_q     <= hwdata[7:0];
				tx_need_q <= 1'b0;
			end
			if (rd_rxd)
				rx_valid_q <= 1'b0;
			unique case (st_q)
				S_IDLE:
				begin
					sclk_q <= 1'b0; // mode 0 idle
					if (start)
					begin
						busy_q    <= 1'b1;
						cs_n_q    <= 1'b0;
						ph_q      <= PH_OP;
						sh_q      <= hwdata[7:0];
						mosi_q    <= hwdata[7];
						bit_q     <= 3'd0;
						tx_need_q <= 1'b0;
						st_q      <= S_SEL;
					end
				end
				S_SEL:
					if (tick)
						st_q <= S_SHIFT;
				S_SHIFT:
					if (tick)
					begin
						if (!sclk_q)
						begin
							// Rising edge: flash samples mosi, host samples miso
							sclk_q <= 1'b1;
							sh_q   <= {sh_q[6:0], miso_s_q};
						end
						else if (!last_bit)
						begin
							// Falling edge: next bit out
							sclk_q <= 1'b0;
							bit_q  <= bit_q + 3'd1;
							mosi_q <= sh_q[7];
						end
						else
						begin
							sclk_q <= 1'b0;
							st_q   <= S_NEXT;
						end
					end
				S_NEXT:
				begin
					// Whole byte done: frame can only end on a byte boundary
					if (in_read)
					begin
						rxd_q      <= sh_q;
						rx_valid_q <= 1'b1;
					end
					bit_q <= 3'd0;
					if (ph_q == PH_OP && cmd_q.naddr != 2'd0)
					begin
						ph_q   <= PH_ADDR;
						cnt_q  <= {10'd0, cmd_q.naddr};
						sh_q   <= addr_first;
						mosi_q <= addr_first[7];
						st_q   <= S_WAIT;
					end
					else if (ph_q == PH_ADDR && cnt_q != 12'd1)
					begin
						cnt_q  <= cnt_q - 12'd1;
						sh_q   <= addr_byte;
						mosi_q <= addr_byte[7];
						st_q   <= S_WAIT;
					end
					else if ((ph_q == PH_OP || ph_q == PH_ADDR) && cmd_q.ndum != 2'd0)
					begin
						ph_q   <= PH_DUM; // dummy byte of fast read
						cnt_q  <= {10'd0, cmd_q.ndum};
						sh_q   <= 8'h00;
						mosi_q <= 1'b0;
						st_q   <= S_WAIT;
					end
					else if (ph_q == PH_DUM && cnt_q != 12'd1)
					begin
						cnt_q <= cnt_q - 12'd1;
						sh_q  <= 8'h00;
						st_q  <= S_WAIT;
					end
					else if (ph_q != PH_DATA && cmd_q.ndat != 12'd0)
					begin
						ph_q      <= PH_DATA;
						cnt_q     <= cmd_q.ndat;
						tx_need_q <= ~cmd_q.rd;
						st_q      <= S_WAIT;
					end
					else if (ph_q == PH_DATA && cnt_q != 12'd1)
					begin
						cnt_q     <= cnt_q - 12'd1;
						tx_need_q <= ~cmd_q.rd;
						st_q      <= S_WAIT;
					end
					else
						st_q <= S_DESEL;
				end
				S_WAIT:
					if (can_shift && tick)
					begin
						if (in_write)
						begin
							sh_q   <= txd_q;
							mosi_q <= txd_q[7];
						end
						st_q <= S_SHIFT;
					end
				S_DESEL:
					if (tick)
					begin
						cs_n_q <= 1'b1; // raised after the last whole byte
						busy_q <= 1'b0;
						st_q   <= S_IDLE;
					end
				default:
					st_q <= S_IDLE;
			endcase
		end
	end

	assign spi_out = '{sclk: sclk_q, cs_n: cs_n_q, mosi: mosi_q};

	// ************************************************************
	// Checks
	// ************************************************************
	property p_edge_on_tick;
		@(posedge hclk) disable iff (!hresetn)
		$rose(sclk_q) |-> $past(st_q) == S_SHIFT;
	endproperty
	a_edge_on_tick: assert property (p_edge_on_tick) else $error("sclk rose outside shift");

	property p_idle_low;
		@(posedge hclk) disable iff (!hresetn)
		cs_n_q |-> !sclk_q;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("sclk high while deselected");

	property p_cs_boundary;
		@(posedge hclk) disable iff (!hresetn)
		$rose(cs_n_q) |-> $past(st_q) == S_DESEL && bit_q == 3'd0;
	endproperty
	a_cs_boundary: assert property (p_cs_boundary) else $error("select rose mid byte");

	property p_mosi_stable_high;
		@(posedge hclk) disable iff (!hresetn)
		sclk_q && $past(sclk_q) |-> $stable(mosi_q);
	endproperty
	a_mosi_stable_high: assert property (p_mosi_stable_high) else $error("mosi moved");

	property p_known_only;
		@(posedge hclk) disable iff (!hresetn)
		$fell(cs_n_q) |-> known_op(cmd_q.op) && known_op(sh_q);
	endproperty
	a_known_only: assert property (p_known_only) else $error("unknown opcode sent");

	property p_busy_frame;
		@(posedge hclk) disable iff (!hresetn)
		!cs_n_q |-> busy_q;
	endproperty
	a_busy_frame: assert property (p_busy_frame) else $error("frame without busy");

	property p_stall_write;
		@(posedge hclk) disable iff (!hresetn)
		st_q == S_WAIT && in_write && tx_need_q |=> st_q == S_WAIT;
	endproperty
	a_stall_write: assert property (p_stall_write) else $error("write ran without data");

	property p_byte_bits;
		@(posedge hclk) disable iff (!hresetn)
		st_q == S_NEXT |-> bit_q == 3'd7;
	endproperty
	a_byte_bits: assert property (p_byte_bits) else $error("byte not eight bits");

	c_read:  cover property (@(posedge hclk) disable iff (!hresetn) $rose(rx_valid_q));
	c_frame: cover property (@(posedge hclk) disable iff (!hresetn) $rose(cs_n_q));
	c_stall: cover property (@(posedge hclk) disable iff (!hresetn) st_q == S_WAIT && tx_need_q);
endmodule

// ===== flash_host_pkg.sv
// Constants, types and command codes for the serial flash host controller.
// Assumes one AHB-Lite master and one serial NOR flash on the SPI pins.
package flash_host_pkg;

	// ************************************************************
	// Register map (word offsets in bytes)
	// ************************************************************
	localparam logic [7:0] CTRL_OFS   = 8'h00; // RW: start, opcode, counts
	localparam logic [7:0] ADDR_OFS   = 8'h04; // RW: 24-bit address
	localparam logic [7:0] TXD_OFS    = 8'h08; // W: write data byte
	localparam logic [7:0] STAT_OFS   = 8'h0C; // R: busy, rx valid, tx need
	localparam logic [7:0] RXD_OFS    = 8'h10; // R: last received byte
	localparam logic [7:0] DIV_OFS    = 8'h14; // RW: clock half-period

	// CTRL fields
	localparam int CTRL_OP_LSB    = 0;
	localparam int CTRL_NADDR_LSB = 8;  // address bytes 0..3
	localparam int CTRL_NDUM_LSB  = 12; // dummy bytes 0..3
	localparam int CTRL_NDAT_LSB  = 16; // data bytes, 0..4095
	localparam int CTRL_RD_BIT    = 30; // data phase reads
	localparam int CTRL_GO_BIT    = 31;

	localparam logic [7:0] DIV_RESET = 8'h02;

	// ************************************************************
	// Command set
	// ************************************************************
	localparam logic [7:0] WRITE_LATCH_ARM_CMD   = 8'h06;
	localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
	localparam logic [7:0] JEDEC_ID_CMD          = 8'h9F;
	localparam logic [7:0] STATUS_FETCH_CMD      = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
	localparam logic [7:0] READ_CMD              = 8'h03;
	localparam logic [7:0] FAST_READ_CMD         = 8'h0B;
	localparam logic [7:0] REGION4K_WIPE_CMD     = 8'h20;
	localparam logic [7:0] BLOCK_WIPE_CMD        = 8'h52;
	localparam logic [7:0] BLOCK_WIPE_ALT_CMD    = 8'hD8;
	localparam logic [7:0] CHIP_WIPE_CMD         = 8'h60;
	localparam logic [7:0] CHIP_WIPE_ALT_CMD     = 8'hC7;
	localparam logic [7:0] PAGE_WRITE_CMD        = 8'h02;
	localparam logic [7:0] DEEP_SLEEP_CMD        = 8'hB9;
	localparam logic [7:0] WAKE_FROM_SLEEP_CMD   = 8'hAB;
	localparam logic [7:0] LEGACY_ID_CMD         = 8'hAB;
	localparam logic [7:0] MAKER_PART_ID_CMD     = 8'h90;

	localparam int BUSY_FLAG_BIT        = 0;
	localparam int WRITE_LATCH_FLAG_BIT = 1;
	localparam int ARRAY_ADDR_W         = 17;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_SEL   = 3'b001,
		S_SHIFT = 3'b011,
		S_NEXT  = 3'b010,
		S_WAIT  = 3'b110,
		S_DESEL = 3'b111
	} seq_state_t;

	typedef enum logic [1:0] {
		PH_OP   = 2'b00,
		PH_ADDR = 2'b01,
		PH_DUM  = 2'b11,
		PH_DATA = 2'b10
	} phase_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} spi_out_t;

	typedef struct packed {
		logic       go;
		logic       rd;
		logic [11:0] ndat;
		logic [1:0] ndum;
		logic [1:0] naddr;
		logic [7:0] op;
	} cmd_t;

	function automatic logic known_op(input logic [7:0] op);
		return op inside {WRITE_LATCH_ARM_CMD, WRITE_LATCH_CLEAR_CMD, JEDEC_ID_CMD,
			STATUS_FETCH_CMD, STATUS_WRITE_CMD, READ_CMD, FAST_READ_CMD,
			REGION4K_WIPE_CMD, BLOCK_WIPE_CMD, BLOCK_WIPE_ALT_CMD, CHIP_WIPE_CMD,
			CHIP_WIPE_ALT_CMD, PAGE_WRITE_CMD, DEEP_SLEEP_CMD, WAKE_FROM_SLEEP_CMD,
			MAKER_PART_ID_CMD};
	endfunction

endpackage

// ===== flash_model.sv
// Behavioural serial NOR flash on the far side of the host's SPI pins.
// Assumes whole-byte frames, sclk idle between frames, host mode 0.
`timescale 1ns/1ps
module flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] MEM_TYPE   = 8'h3C, // Arbitrary value
	parameter logic [7:0] CAPACITY   = 8'h4B, // Arbitrary value
	parameter logic [7:0] DEV_CODE   = 8'h17, // Arbitrary value
	parameter int         BUSY_NS    = 10000
) (
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	output logic      miso
);
	import flash_host_pkg::*;

	logic [7:0]  mem [0:131071];
	logic [7:0]  sr, op;
	logic [23:0] addr;
	logic [8:0]  ob;
	logic        write_latch_flag, busy, asleep, active;
	int          nbits;
	logic [7:0]  pdat [$];

	// ************************************************************
	// Serial front end
	// ************************************************************
	initial
	begin
		for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
		write_latch_flag = 1'b0;
		{busy, asleep, active, miso} = 4'h0;
	end

	always @(negedge cs_n)
	begin
		nbits = 0;
		active = 1'b1;
		pdat.delete();
	end

	always @(posedge sclk) if (!cs_n && active)
	begin
		sr = {sr[6:0], mosi};
		nbits++;
		if (nbits == 8)
		begin
			op = sr;
			// Busy: only status fetch is decoded; asleep: only wake is decoded
			if (!known_op(op) || (busy && op != STATUS_FETCH_CMD)
				|| (asleep && op != WAKE_FROM_SLEEP_CMD)) active = 1'b0;
		end
		else if (nbits % 8 == 0 && nbits <= 32) addr = {addr[15:0], sr};
		if (nbits % 8 == 0 && nbits > 32 && op == PAGE_WRITE_CMD) pdat.push_back(sr);
	end

	function automatic logic [8:0] out_byte(input int j);
		logic [16:0] a;
		a = addr[16:0] + 17'(j - (op == FAST_READ_CMD ? 5 : 4));
		case (op)
			JEDEC_ID_CMD:      return {j <= 3, j == 1 ? MAKER_CODE : j == 2 ? MEM_TYPE : CAPACITY};
			STATUS_FETCH_CMD:  return {3'b100, 4'h0, write_latch_flag, busy};
			READ_CMD:          return {j >= 4, mem[a]};
			FAST_READ_CMD:     return {j >= 5, mem[a]};
			LEGACY_ID_CMD:     return {j >= 4, DEV_CODE};
			MAKER_PART_ID_CMD: return {j >= 4, (j + addr[0]) % 2 == 0 ? MAKER_CODE : DEV_CODE};
			default:           return 9'h000;
		endcase
	endfunction

	// Released line toggles so a stale bit never passes for data
	always @(negedge sclk) if (!cs_n)
	begin
		ob = out_byte(nbits / 8);
		if (active && ob[8]) miso = ob[7 - nbits % 8];
		else miso = ~miso;
	end

	// ************************************************************
	// Execution at select release
	// ************************************************************
	always @(posedge cs_n)
	begin
		miso = ~miso;
		if (active && nbits >= 8 && nbits % 8 == 0)
			case (op)
				WRITE_LATCH_ARM_CMD:   write_latch_flag = 1'b1;
				WRITE_LATCH_CLEAR_CMD: write_latch_flag = 1'b0;
				DEEP_SLEEP_CMD:        asleep = 1'b1;
				WAKE_FROM_SLEEP_CMD:   asleep = 1'b0;
				STATUS_WRITE_CMD, PAGE_WRITE_CMD, REGION4K_WIPE_CMD, BLOCK_WIPE_CMD,
				BLOCK_WIPE_ALT_CMD, CHIP_WIPE_CMD, CHIP_WIPE_ALT_CMD:
					if (write_latch_flag)
					begin
						apply_write();
						busy = 1'b1;
					end
				default: ;
			endcase
		active = 1'b0;
	end

	task automatic apply_write;
		case (op)
			PAGE_WRITE_CMD: foreach (pdat[i]) mem[{addr[16:8], 8'(addr[7:0] + i)}] &= pdat[i];
			REGION4K_WIPE_CMD: for (int i = 0; i < 4096; i++) mem[{addr[16:12], 12'(i)}] = 8'hFF;
			BLOCK_WIPE_CMD, BLOCK_WIPE_ALT_CMD:
				for (int i = 0; i < 65536; i++) mem[{addr[16], 16'(i)}] = 8'hFF;
			CHIP_WIPE_CMD, CHIP_WIPE_ALT_CMD: for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
			default: ;
		endcase
	endtask

	always @(posedge busy)
	begin
		#(BUSY_NS);
		busy = 1'b0;
		write_latch_flag = 1'b0;
	end
endmodule

// ===== test_flash_host.sv
// Self-checking bench: AHB-Lite register tasks drive the host against a flash model.
// Assumes the host answers with zero wait states and OKAY.
`timescale 1ns/1ps
module test_flash_host;
	import flash_host_pkg::*;

	localparam logic [7:0] MAKER_CODE = 8'h5A; // Arbitrary value
	localparam logic [7:0] MEM_TYPE   = 8'h3C; // Arbitrary value
	localparam logic [7:0] CAPACITY   = 8'h4B; // Arbitrary value
	localparam logic [7:0] DEV_CODE   = 8'h17; // Arbitrary value

	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, hreadyout, hresp, miso;
	logic [31:0] haddr, hwdata, hrdata, s;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	spi_out_t    spi_out;
	logic [7:0]  tx [0:3];
	logic [7:0]  rx [0:3];
	logic [7:0]  wipe [0:4] = '{REGION4K_WIPE_CMD, BLOCK_WIPE_CMD, BLOCK_WIPE_ALT_CMD,
		CHIP_WIPE_CMD, CHIP_WIPE_ALT_CMD};
	int          err_count = 0;
	int          compares = 0;

	always #12.5 hclk = ~hclk;

	flash_host DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.spi_out(spi_out), .miso(miso));

	flash_model #(.MAKER_CODE(MAKER_CODE), .MEM_TYPE(MEM_TYPE), .CAPACITY(CAPACITY),
		.DEV_CODE(DEV_CODE), .BUSY_NS(10000)) flash (.sclk(spi_out.sclk),
		.cs_n(spi_out.cs_n), .mosi(spi_out.mosi), .miso(miso));

	// ************************************************************
	// Bus and command tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (err_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		s = hrdata;
	endtask

	// Only defined opcodes are sent, in whole bytes
	task automatic cmd(input logic [7:0] op, input int na, nd, n, input logic rd,
		input logic [23:0] a);
		ahb(1'b1, ADDR_OFS, {8'h00, a});
		ahb(1'b1, CTRL_OFS, 32'(op) | (32'(na) << CTRL_NADDR_LSB) | (32'(nd) << CTRL_NDUM_LSB)
			| (32'(n) << CTRL_NDAT_LSB) | (32'(rd) << CTRL_RD_BIT) | (32'h1 << CTRL_GO_BIT));
		for (int i = 0; i < n; i++)
		begin
			do ahb(1'b0, STAT_OFS, 32'h0); while (s[rd ? 1 : 2] !== 1'b1);
			if (rd) ahb(1'b0, RXD_OFS, 32'h0);
			else ahb(1'b1, TXD_OFS, {24'h0, tx[i]});
			rx[i] = s[7:0];
		end
		do ahb(1'b0, STAT_OFS, 32'h0); while (s[0] !== 1'b0);
	endtask

	task automatic wait_ready;
		do cmd(STATUS_FETCH_CMD, 0, 0, 1, 1, 0); while (rx[0][0] !== 1'b0);
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial
	begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, DIV_OFS, 32'h0);
		check(s, {24'h0, DIV_RESET});
		ahb(1'b1, DIV_OFS, 32'h3);
		ahb(1'b0, DIV_OFS, 32'h0);
		check(s, 32'h3);
		ahb(1'b0, 8'h18, 32'h0);
		check({31'h0, hresp}, 32'h0);
		cmd(JEDEC_ID_CMD, 0, 0, 3, 1, 0);
		check(rx[0], MAKER_CODE);
		check(rx[1], MEM_TYPE);
		check(rx[2], CAPACITY);
		wait_ready();
		check(rx[0], 8'h00);
		cmd(WRITE_LATCH_ARM_CMD, 0, 0, 0, 0, 0);
		wait_ready();
		check(rx[0], 8'h02);
		cmd(WRITE_LATCH_CLEAR_CMD, 0, 0, 0, 0, 0);
		wait_ready();
		check(rx[0], 8'h00);
		tx = '{8'hA5, 8'h3C, 8'h00, 8'h00};
		cmd(PAGE_WRITE_CMD, 3, 0, 2, 0, 24'h012345);
		cmd(READ_CMD, 3, 0, 2, 1, 24'h012345);
		check({rx[0], rx[1]}, 16'hFFFF);
		cmd(WRITE_LATCH_ARM_CMD, 0, 0, 0, 0, 0);
		cmd(PAGE_WRITE_CMD, 3, 0, 2, 0, 24'h012345);
		cmd(STATUS_FETCH_CMD, 0, 0, 1, 1, 0);
		check(rx[0], 8'h03);
		wait_ready();
		check(rx[0], 8'h00);
		cmd(READ_CMD, 3, 0, 2, 1, 24'h012345);
		check({rx[0], rx[1]}, 16'hA53C);
		cmd(FAST_READ_CMD, 3, 1, 2, 1, 24'h012345);
		check({rx[0], rx[1]}, 16'hA53C);
		for (int k = 0; k < 2; k++)
		begin
			cmd(MAKER_PART_ID_CMD, 3, 0, 2, 1, 24'(k));
			check({rx[0], rx[1]}, k ? {DEV_CODE, MAKER_CODE} : {MAKER_CODE, DEV_CODE});
		end
		cmd(DEEP_SLEEP_CMD, 0, 0, 0, 0, 0);
		cmd(WAKE_FROM_SLEEP_CMD, 0, 3, 1, 1, 0);
		check(rx[0], DEV_CODE);
		cmd(WRITE_LATCH_ARM_CMD, 0, 0, 0, 0, 0);
		cmd(STATUS_WRITE_CMD, 0, 0, 1, 0, 0);
		cmd(STATUS_FETCH_CMD, 0, 0, 1, 1, 0);
		check(rx[0], 8'h03);
		wait_ready();
		check(rx[0], 8'h00);
		// Block 0 byte survives sector and block wipes of block 1
		for (int k = 0; k < 5; k++)
		begin
			tx[0] = 8'h77;
			cmd(WRITE_LATCH_ARM_CMD, 0, 0, 0, 0, 0);
			cmd(PAGE_WRITE_CMD, 3, 0, 1, 0, 24'h00F000);
			wait_ready();
			cmd(WRITE_LATCH_ARM_CMD, 0, 0, 0, 0, 0);
			cmd(PAGE_WRITE_CMD, 3, 0, 1, 0, 24'h012000);
			wait_ready();
			cmd(WRITE_LATCH_ARM_CMD, 0, 0, 0, 0, 0);
			cmd(wipe[k], k < 3 ? 3 : 0, 0, 0, 0, 24'h012FFF);
			wait_ready();
			check(rx[0], 8'h00);
			cmd(READ_CMD, 3, 0, 1, 1, 24'h012000);
			check(rx[0], 8'hFF);
			cmd(READ_CMD, 3, 0, 1, 1, 24'h00F000);
			check(rx[0], k < 3 ? 8'h77 : 8'hFF);
		end
		give_verdict();
	end

	initial
	begin
		repeat (90000) @(posedge hclk);
		err_count++;
		give_verdict();
	end
endmodule
